//--- design/cbx_branch_exec.sv
// Conditional branch, indirect jump and pointer increment execution slice of the core.
// Assumes the core offers instruction bytes in order with the address of the first byte on pc_in,
// answers a bit read one cycle after bit_rd_q, and applies pc_load_q, data_pointer_wr_q and bit_wr_q.
//
// Notes on behaviour
// - The pointer increment adds one to the 16-bit data pointer, wrapping modulo 65536.
// - The pointer increment never carries into the pointer extension word.
// - The legacy jump-if-bit-set moves past its 3 bytes and adds the displacement when the bit is one.
// - Bit-testing branches other than jump-bit-set-and-clear leave the bit alone; all take the displacement from the last byte.
// - A relative target is the next instruction address plus the signed displacement.
// - Jump-bit-set-and-clear clears and branches on a one, and neither writes nor branches on a zero.
// - Jump-bit-set-and-clear reads a port bit from its output latch, not the pin.
// - The carry jump moves past 2 bytes and branches only when the carry flag is one.
// - The equal jump branches only when the zero flag is one.
// - The unsigned greater jump branches only when zero and carry are both clear.
// - The unsigned less-or-equal jump branches when zero or carry is set.
// - The indirect jump loads accumulator plus data pointer into the low 16 PC bits.
// - Jump-if-bit-clear branches only on a zero bit, the legacy form moving past 3 bytes.
// - Extended bit branches and the equal, greater and less-or-equal jumps need the A5 escape in binary mode and none in source mode.
// - Legacy forms decode without escape in both modes.
//
// The strobed register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
module cbx_branch_exec
  import cbx_pkg::*;
(
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // Instruction byte stream
  input  wire logic               ins_valid,
  input  wire logic [BYTE_W-1:0]  ins_byte,
  input  wire logic [PC_W-1:0]    pc_in,
  output logic                    ins_ready_q,
  // Core state
  input  wire cbx_core_s          core_in,
  // Bit space
  output logic                    bit_rd_q,
  output logic                    bit_wr_q,
  output cbx_bit_s                bit_req_q,
  input  wire logic               bit_rd_data,
  // Results
  output logic                    done_q,
  output logic                    unhandled_q,
  output logic                    pc_load_q,
  output logic      [PC_W-1:0]    pc_value_q,
  output logic                    data_pointer_wr_q,
  output logic      [LOW_W-1:0]   data_pointer_value_q,
  // Register port
  input  wire logic [RADDR_W-1:0] reg_addr,
  input  wire logic [RDATA_W-1:0] reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [RDATA_W-1:0] reg_rdata_q
);

  cbx_state_e        state_q;
  cbx_state_e        state_d;
  cbx_op_e           kind_q;
  cbx_dec_s          dec;
  logic              take;
  logic              pfx_q;
  logic              src_mode_q;
  logic [1:0]        nops_q;
  logic [1:0]        idx_q;
  logic [SIZE_W-1:0] size_q;
  logic [PC_W-1:0]   pc_base_q;
  logic [BYTE_W-1:0] op0_q;
  logic [BYTE_W-1:0] op1_q;
  logic [BYTE_W-1:0] rel_q;
  logic              taken_q;
  logic              last_taken_q;
  logic              unhandled_seen_q;
  logic [LOW_W-1:0]  target_low_q;
  logic              last_op;
  logic              bad_sub;
  logic              bit_kind;
  logic              flag_cond;
  logic              bit_cond;
  logic              set_unhandled;
  logic [PC_W-1:0]   seq_pc_q;
  logic [PC_W-1:0]   rel_pc_q;

  // ****************************************************************
  // Decoding
  // ****************************************************************
  function automatic cbx_dec_s decode(input logic [7:0] b, input logic prefixed, input logic src_mode);
    cbx_dec_s d;
    logic     ext_ok;
    d      = '{hit: 1'b0, kind: OP_INC_DATA_POINTER, nops: NOPS_NONE};
    ext_ok = prefixed ^ src_mode;
    case (b)
      OPC_INC_DATA_POINTER: d = '{hit: !prefixed, kind: OP_INC_DATA_POINTER, nops: NOPS_NONE};
      OPC_JB_LEG:   d = '{hit: !prefixed, kind: OP_JB,       nops: NOPS_LEG_BIT};
      OPC_JBC_LEG:  d = '{hit: !prefixed, kind: OP_JBC,      nops: NOPS_LEG_BIT};
      OPC_JNB_LEG:  d = '{hit: !prefixed, kind: OP_JNB,      nops: NOPS_LEG_BIT};
      OPC_JC:       d = '{hit: !prefixed, kind: OP_JC,       nops: NOPS_REL};
      OPC_IND_JMP:  d = '{hit: !prefixed, kind: OP_IND_JMP,  nops: NOPS_NONE};
      OPC_BIT_EXT:  d = '{hit: ext_ok,    kind: OP_EXT_BIT,  nops: NOPS_EXT_BIT};
      OPC_JE:       d = '{hit: ext_ok,    kind: OP_JE,       nops: NOPS_REL};
      OPC_JG:       d = '{hit: ext_ok,    kind: OP_JG,       nops: NOPS_REL};
      OPC_JLE:      d = '{hit: ext_ok,    kind: OP_JLE,      nops: NOPS_REL};
      default:      d = '{hit: 1'b0,      kind: OP_INC_DATA_POINTER, nops: NOPS_NONE};
    endcase
    return d;
  endfunction

  function automatic cbx_op_e sub_kind(input logic [3:0] nib);
    cbx_op_e k;
    case (nib)
      SUB_JBC: k = OP_JBC;
      SUB_JNB: k = OP_JNB;
      default: k = OP_JB;
    endcase
    return k;
  endfunction

  always_comb begin
    take     = ins_valid && ins_ready_q;
    dec      = decode(ins_byte, pfx_q, src_mode_q);
    last_op  = (idx_q == nops_q - 2'h1);
    bad_sub  = (kind_q == OP_EXT_BIT) && (idx_q == 2'h0) &&
               (ins_byte[SUB_RSV] ||
                !(ins_byte[SUB_HI:SUB_LO] inside {SUB_JB, SUB_JBC, SUB_JNB}));
    bit_kind = kind_q inside {OP_JB, OP_JBC, OP_JNB};
  end

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  always_comb begin
    state_d       = state_q;
    set_unhandled = 1'b0;
    case (state_q)
      ST_FETCH, ST_PREFIX: begin
        if (take) begin
          if (state_q == ST_FETCH && ins_byte == OPC_ESCAPE) begin
            state_d = ST_PREFIX;
          end else if (!dec.hit) begin
            state_d       = ST_FETCH;
            set_unhandled = 1'b1;
          end else if (dec.nops == NOPS_NONE) begin
            state_d = ST_CALC;
          end else begin
            state_d = ST_OPER;
          end
        end
      end
      ST_OPER: begin
        if (take) begin
          if (bad_sub) begin
            state_d       = ST_FETCH;
            set_unhandled = 1'b1;
          end else if (last_op) begin
            state_d = bit_kind ? ST_BITRD : ST_CALC;
          end
        end
      end
      ST_BITRD:  state_d = ST_BITCHK;
      ST_BITCHK: state_d = ST_CALC;
      ST_CALC:   state_d = ST_DONE;
      ST_DONE:   state_d = ST_FETCH;
      default:   state_d = ST_FETCH;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q     <= ST_FETCH;
      ins_ready_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      ins_ready_q <= state_d inside {ST_FETCH, ST_PREFIX, ST_OPER};
    end
  end

  // ****************************************************************
  // Instruction capture
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      pfx_q     <= 1'b0;
      kind_q    <= OP_INC_DATA_POINTER;
      nops_q    <= NOPS_NONE;
      idx_q     <= 2'h0;
      size_q    <= '0;
      pc_base_q <= '0;
      op0_q     <= '0;
      op1_q     <= '0;
      rel_q     <= '0;
    end else if (take) begin
      size_q <= size_q + SIZE_W'(1);
      case (state_q)
        ST_FETCH: begin
          pc_base_q <= pc_in;
          size_q    <= SIZE_W'(1);
          pfx_q     <= (ins_byte == OPC_ESCAPE);
          kind_q    <= dec.kind;
          nops_q    <= dec.nops;
          idx_q     <= 2'h0;
        end
        ST_PREFIX: begin
          pfx_q  <= 1'b0;
          kind_q <= dec.kind;
          nops_q <= dec.nops;
          idx_q  <= 2'h0;
        end
        ST_OPER: begin
          idx_q <= idx_q + 2'h1;
          if (last_op) begin
            rel_q <= ins_byte;
          end else if (idx_q == 2'h0) begin
            op0_q <= ins_byte;
            if (kind_q == OP_EXT_BIT) begin
              kind_q <= sub_kind(ins_byte[SUB_HI:SUB_LO]);
            end
          end else begin
            op1_q <= ins_byte;
          end
        end
        default: begin
          idx_q <= idx_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // Bit space access
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      bit_rd_q  <= 1'b0;
      bit_wr_q  <= 1'b0;
      bit_req_q <= '0;
    end else begin
      bit_rd_q <= (state_d == ST_BITRD);
      // A set bit is cleared only for the clearing form; a zero bit is never rewritten.
      bit_wr_q <= (state_q == ST_BITCHK) && (kind_q == OP_JBC) && bit_rd_data;
      if (state_d == ST_BITRD) begin
        bit_req_q.legacy     <= (nops_q == NOPS_LEG_BIT);
        bit_req_q.from_latch <= (kind_q == OP_JBC);
        bit_req_q.addr       <= (nops_q == NOPS_LEG_BIT) ? op0_q : op1_q;
        bit_req_q.pos        <= (nops_q == NOPS_LEG_BIT) ? 3'h0 : op0_q[POS_HI:0];
      end
    end
  end

  // ****************************************************************
  // Branch conditions
  // ****************************************************************
  always_comb begin
    case (kind_q)
      OP_JC:   flag_cond = core_in.carry_flag;
      OP_JE:   flag_cond = core_in.zero_flag;
      OP_JG:   flag_cond = !core_in.zero_flag && !core_in.carry_flag;
      OP_JLE:  flag_cond = core_in.zero_flag || core_in.carry_flag;
      default: flag_cond = 1'b0;
    endcase
    bit_cond = (kind_q == OP_JNB) ? !bit_rd_data : bit_rd_data;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      taken_q <= 1'b0;
    end else if (state_q == ST_BITCHK) begin
      taken_q <= bit_cond;
    end else if (state_q == ST_CALC && !bit_kind) begin
      taken_q <= flag_cond;
    end
  end

  cbx_target_calc u_target_calc (
    .mclk     (mclk),
    .reset    (reset),
    .calc_go  (state_q == ST_CALC),
    .pc_base  (pc_base_q),
    .size     (size_q),
    .rel      (rel_q),
    .seq_pc_q (seq_pc_q),
    .rel_pc_q (rel_pc_q)
  );

  // ****************************************************************
  // Results
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      done_q       <= 1'b0;
      pc_load_q    <= 1'b0;
      pc_value_q   <= '0;
      data_pointer_wr_q    <= 1'b0;
      data_pointer_value_q <= '0;
    end else begin
      done_q    <= (state_q == ST_DONE);
      pc_load_q <= (state_q == ST_DONE);
      data_pointer_wr_q <= (state_q == ST_DONE) && (kind_q == OP_INC_DATA_POINTER);
      if (state_q == ST_DONE) begin
        if (kind_q == OP_IND_JMP) begin
          pc_value_q <= {pc_base_q[PC_W-1:LOW_W],
                         core_in.data_pointer + LOW_W'(core_in.accumulator)};
        end else if (kind_q == OP_INC_DATA_POINTER) begin
          pc_value_q <= seq_pc_q;
        end else begin
          pc_value_q <= taken_q ? rel_pc_q : seq_pc_q;
        end
        // Only the low 16 bits are produced, so no carry can reach the extension word.
        data_pointer_value_q <= core_in.data_pointer + LOW_W'(1);
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      unhandled_q <= 1'b0;
    end else begin
      unhandled_q <= set_unhandled;
    end
  end

  // ****************************************************************
  // Register port
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (reset) begin
      src_mode_q <= 1'b0;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      src_mode_q <= reg_wdata[CTRL_SRC];
    end
  end

  // The sticky unhandled flag clears on a written one, but a new event in the same cycle wins.
  always_ff @(posedge mclk) begin
    if (reset) begin
      unhandled_seen_q <= 1'b0;
    end else if (set_unhandled) begin
      unhandled_seen_q <= 1'b1;
    end else if (reg_wr && reg_addr == REG_STATUS && reg_wdata[ST_UNHANDLED]) begin
      unhandled_seen_q <= 1'b0;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      last_taken_q <= 1'b0;
      target_low_q <= '0;
    end else if (state_q == ST_DONE) begin
      last_taken_q <= taken_q && !(kind_q inside {OP_INC_DATA_POINTER, OP_IND_JMP});
      target_low_q <= rel_pc_q[LOW_W-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_rdata_q <= '0;
    end else if (reg_rd) begin
      reg_rdata_q <= '0;
      case (reg_addr)
        REG_CTRL: begin
          reg_rdata_q[CTRL_SRC] <= src_mode_q;
        end
        REG_STATUS: begin
          reg_rdata_q[ST_TAKEN]     <= last_taken_q;
          reg_rdata_q[ST_UNHANDLED] <= unhandled_seen_q;
          reg_rdata_q[ST_BUSY]      <= (state_q != ST_FETCH);
        end
        REG_TARGET: begin
          reg_rdata_q <= target_low_q;
        end
        default: begin
          reg_rdata_q <= '0;
        end
      endcase
    end else begin
      reg_rdata_q <= '0;
    end
  end

endmodule

//--- design/cbx_pkg.sv
// Shared constants, encodings and carrier types of the conditional branch execution slice.
// Assumes a core that feeds instruction bytes in order and owns flags, bit space and program counter.
package cbx_pkg;

  // ****************************************************************
  // Widths
  // ****************************************************************
  localparam int unsigned PC_W    = 24;
  localparam int unsigned LOW_W   = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned SIZE_W  = 3;
  localparam int unsigned RADDR_W = 4;
  localparam int unsigned RDATA_W = 16;

  // ****************************************************************
  // Opcodes
  // ****************************************************************
  localparam logic [7:0] OPC_ESCAPE   = 8'hA5;
  localparam logic [7:0] OPC_INC_DATA_POINTER = 8'hA3;
  localparam logic [7:0] OPC_JB_LEG   = 8'h20;
  localparam logic [7:0] OPC_JBC_LEG  = 8'h10;
  localparam logic [7:0] OPC_JNB_LEG  = 8'h30;
  localparam logic [7:0] OPC_JC       = 8'h40;
  localparam logic [7:0] OPC_IND_JMP  = 8'h73;
  localparam logic [7:0] OPC_BIT_EXT  = 8'hA9;
  localparam logic [7:0] OPC_JE       = 8'h68;
  localparam logic [7:0] OPC_JG       = 8'h38;
  localparam logic [7:0] OPC_JLE      = 8'h28;

  // Sub-opcode nibble of the extended bit form, byte layout 0yyy in the high nibble.
  localparam logic [3:0] SUB_JB       = 4'h2;
  localparam logic [3:0] SUB_JBC      = 4'h1;
  localparam logic [3:0] SUB_JNB      = 4'h3;
  localparam int unsigned SUB_HI      = 7;
  localparam int unsigned SUB_LO      = 4;
  localparam int unsigned SUB_RSV     = 3;
  localparam int unsigned POS_HI      = 2;

  // Operand byte counts after the opcode.
  localparam logic [1:0] NOPS_NONE    = 2'h0;
  localparam logic [1:0] NOPS_REL     = 2'h1;
  localparam logic [1:0] NOPS_LEG_BIT = 2'h2;
  localparam logic [1:0] NOPS_EXT_BIT = 2'h3;

  // ****************************************************************
  // Software register map
  // ****************************************************************
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_STATUS   = 4'h1;
  localparam logic [3:0] REG_TARGET   = 4'h2;
  localparam int unsigned CTRL_SRC    = 0;
  localparam int unsigned ST_TAKEN    = 0;
  localparam int unsigned ST_UNHANDLED = 1;
  localparam int unsigned ST_BUSY     = 2;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_INC_DATA_POINTER = 4'h0,
    OP_JB       = 4'h1,
    OP_JBC      = 4'h2,
    OP_JNB      = 4'h3,
    OP_JC       = 4'h4,
    OP_JE       = 4'h5,
    OP_JG       = 4'h6,
    OP_JLE      = 4'h7,
    OP_IND_JMP  = 4'h8,
    OP_EXT_BIT  = 4'h9
  } cbx_op_e;

  typedef enum logic [2:0] {
    ST_FETCH  = 3'b000,
    ST_PREFIX = 3'b001,
    ST_OPER   = 3'b010,
    ST_BITRD  = 3'b011,
    ST_BITCHK = 3'b100,
    ST_CALC   = 3'b101,
    ST_DONE   = 3'b110
  } cbx_state_e;

  typedef struct packed {
    logic       hit;
    cbx_op_e    kind;
    logic [1:0] nops;
  } cbx_dec_s;

  typedef struct packed {
    logic              carry_flag;
    logic              zero_flag;
    logic [BYTE_W-1:0] accumulator;
    logic [LOW_W-1:0]  data_pointer;
  } cbx_core_s;

  typedef struct packed {
    logic              legacy;
    logic              from_latch;
    logic [BYTE_W-1:0] addr;
    logic [2:0]        pos;
  } cbx_bit_s;

endpackage

//--- design/cbx_target_calc.sv
// Registered relative target arithmetic for the branch execution slice.
// Assumes its inputs stand steady in the cycle of calc_go; results stand from the next edge.
`timescale 1ns/1ns
module cbx_target_calc
  import cbx_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Operands
  input  wire logic              calc_go,
  input  wire logic [PC_W-1:0]   pc_base,
  input  wire logic [SIZE_W-1:0] size,
  input  wire logic [BYTE_W-1:0] rel,
  // Results
  output logic      [PC_W-1:0]   seq_pc_q,
  output logic      [PC_W-1:0]   rel_pc_q
);

  logic [PC_W-1:0] seq_pc;

  // ****************************************************************
  // Arithmetic
  // ****************************************************************
  always_comb begin
    seq_pc = pc_base + PC_W'(size);
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      seq_pc_q <= '0;
      rel_pc_q <= '0;
    end else if (calc_go) begin
      seq_pc_q <= seq_pc;
      rel_pc_q <= seq_pc + {{(PC_W-BYTE_W){rel[BYTE_W-1]}}, rel};
    end
  end

endmodule

//--- bench/cbx_branch_exec_asserts.sv
// Concurrent checks on the ports of the branch execution slice.
// Assumes a single clock mclk and the synchronous high reset of the design.
`timescale 1ns/1ns
module cbx_branch_exec_asserts
  import cbx_pkg::*;
(
  // Clock and reset
  input wire logic             mclk,
  input wire logic             reset,
  // Watched ports
  input wire logic             ins_ready_q,
  input wire cbx_core_s        core_in,
  input wire logic             bit_rd_q,
  input wire logic             bit_wr_q,
  input wire cbx_bit_s         bit_req_q,
  input wire logic             bit_rd_data,
  input wire logic             done_q,
  input wire logic             unhandled_q,
  input wire logic             pc_load_q,
  input wire logic             data_pointer_wr_q,
  input wire logic [LOW_W-1:0] data_pointer_value_q
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);

  AST_DATA_POINTER_VAL: assert property (data_pointer_wr_q |-> data_pointer_value_q == core_in.data_pointer + 16'h0001)
    else $error("pointer increment value wrong");
  AST_DATA_POINTER_DONE: assert property (data_pointer_wr_q |-> done_q && !bit_wr_q && !bit_rd_q)
    else $error("pointer write outside its completion");
  AST_WR_CAUSE: assert property (bit_wr_q |-> $past(bit_rd_q, 2) && $past(bit_rd_data) && bit_req_q.from_latch)
    else $error("bit clear without a set bit");
  AST_WR_FOLLOWS: assert property (bit_rd_q && bit_req_q.from_latch ##1 bit_rd_data |=> bit_wr_q)
    else $error("set bit was not cleared");
  AST_NO_WR_ZERO: assert property (bit_rd_q ##1 !bit_rd_data |=> !bit_wr_q [*3])
    else $error("bit written after reading zero");
  AST_WR_LATCH: assert property (bit_rd_q && bit_req_q.from_latch |-> !bit_req_q.legacy || bit_req_q.pos == 3'h0)
    else $error("latch read carries a bad position");
  AST_BIT_DONE: assert property (bit_rd_q |-> ##4 done_q)
    else $error("bit branch did not finish in time");
  AST_READY_LOW: assert property (bit_rd_q |-> !ins_ready_q && !done_q)
    else $error("bytes accepted during a bit test");
  AST_LOAD_DONE: assert property (pc_load_q |-> done_q && !unhandled_q)
    else $error("counter load outside completion");
  AST_UNH_QUIET: assert property (unhandled_q |-> !done_q && !bit_rd_q && !data_pointer_wr_q)
    else $error("refused byte caused activity");

  CV_DATA_POINTER: cover property (data_pointer_wr_q);
  CV_CLEAR: cover property (bit_wr_q);
  CV_REFUSE: cover property (unhandled_q);
endmodule

bind cbx_branch_exec cbx_branch_exec_asserts u_asserts (.mclk(mclk), .reset(reset), .ins_ready_q(ins_ready_q),
  .core_in(core_in), .bit_rd_q(bit_rd_q), .bit_wr_q(bit_wr_q), .bit_req_q(bit_req_q), .bit_rd_data(bit_rd_data),
  .done_q(done_q), .unhandled_q(unhandled_q), .pc_load_q(pc_load_q), .data_pointer_wr_q(data_pointer_wr_q),
  .data_pointer_value_q(data_pointer_value_q));

//--- bench/cbx_branch_exec_tb_top.sv
// Self-checking bench for the branch execution slice.
// Assumes the bench plays the core, the bit space and the register master.
`timescale 1ns/1ns
module cbx_branch_exec_tb_top
  import cbx_pkg::*;
;
  localparam logic [23:0] P = 24'h0100F0;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  logic              ins_valid = 1'b0;
  logic [7:0]        ins_byte = 8'h00;
  logic [23:0]       pc_in = 24'h0;
  cbx_core_s         core_in = '0;
  logic              bit_rd_data = 1'b0;
  logic [3:0]        reg_addr = 4'h0;
  logic [15:0]       reg_wdata = 16'h0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic              ins_ready_q, bit_rd_q, bit_wr_q, done_q, unhandled_q, pc_load_q, data_pointer_wr_q;
  cbx_bit_s          bit_req_q;
  logic [23:0]       pc_value_q;
  logic [15:0]       data_pointer_value_q, reg_rdata_q;
  int                n_mismatch = 0;
  int                n_compared = 0;

  cbx_branch_exec dut (.mclk(mclk), .reset(reset), .ins_valid(ins_valid), .ins_byte(ins_byte), .pc_in(pc_in),
    .ins_ready_q(ins_ready_q), .core_in(core_in), .bit_rd_q(bit_rd_q), .bit_wr_q(bit_wr_q),
    .bit_req_q(bit_req_q), .bit_rd_data(bit_rd_data), .done_q(done_q), .unhandled_q(unhandled_q),
    .pc_load_q(pc_load_q), .pc_value_q(pc_value_q), .data_pointer_wr_q(data_pointer_wr_q), .data_pointer_value_q(data_pointer_value_q),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q));

  always #5 mclk = ~mclk;

  // *****
  // Helpers
  // *****
  function automatic logic [23:0] tgt(input logic [23:0] pc, input logic [23:0] sz, input logic [7:0] rel,
                                      input logic tk);
    tgt = pc + sz + (tk ? {{16{rel[7]}}, rel} : 24'h0);
  endfunction

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus_write(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_read(input logic [3:0] a, input logic [15:0] m, input logic [15:0] exp);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(posedge mclk);
    chk("reg_rdata", exp, reg_rdata_q & m);
  endtask

  // Bytes go lowest first; the wait after them also notes whether any bit clear was seen.
  task automatic run(input logic [39:0] b, input int n, input logic [23:0] pc, input logic bv,
                     input logic [23:0] exp_pc, input logic unh, input logic wr);
    int k;
    logic seen;
    seen = 1'b0;
    pc_in <= pc;
    bit_rd_data <= bv;
    for (int i = 0; i < n; i++) begin
      ins_valid <= 1'b1;
      ins_byte <= b[8*i +: 8];
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (ins_ready_q !== 1'b1 && k < 20);
      chk("ins_ready", 1'b1, ins_ready_q);
    end
    ins_valid <= 1'b0;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
      if (bit_wr_q === 1'b1) seen = 1'b1;
    end while (done_q !== 1'b1 && unhandled_q !== 1'b1 && k < 30);
    chk("unhandled", unh, unhandled_q);
    chk("done", !unh, done_q);
    chk("bit_clear", wr, seen);
    if (!unh && exp_pc !== 24'h0) chk("pc_value", exp_pc, pc_value_q);
    if (!unh && exp_pc !== 24'h0) chk("pc_load", 1'b1, pc_load_q);
  endtask

  // *****
  // Scenarios
  // *****
  task automatic t_inc();
    core_in <= {2'b00, 8'h00, 16'hFFFF};
    run({32'h0, OPC_INC_DATA_POINTER}, 1, P, 1'b0, tgt(P, 1, 8'h00, 1'b0), 1'b0, 1'b0);
    chk("data_pointer_value", 16'h0000, data_pointer_value_q);
    core_in <= {2'b00, 8'h00, 16'h12FF};
    run({32'h0, OPC_INC_DATA_POINTER}, 1, P, 1'b0, tgt(P, 1, 8'h00, 1'b0), 1'b0, 1'b0);
    chk("data_pointer_value", 16'h1300, data_pointer_value_q);
    $display("test pointer increment done");
  endtask

  task automatic t_legacy();
    logic [7:0] op;
    logic tk;
    for (int i = 0; i < 6; i++) begin
      op = (i < 2) ? OPC_JB_LEG : (i < 4) ? OPC_JNB_LEG : OPC_JBC_LEG;
      tk = (op == OPC_JNB_LEG) ? !i[0] : i[0];
      run({16'h0, 8'h80, 8'h2F, op}, 3, P, i[0], tgt(P, 3, 8'h80, tk), 1'b0, tk && op == OPC_JBC_LEG);
      chk("bit_req", {1'b1, op == OPC_JBC_LEG, 8'h2F, 3'h0}, bit_req_q);
    end
    $display("test legacy bit branches done");
  endtask

  task automatic t_ind();
    core_in <= {2'b00, 8'hFF, 16'hFFF0};
    run({32'h0, OPC_IND_JMP}, 1, 24'h3A1234, 1'b0, 24'h3A00EF, 1'b0, 1'b0);
    $display("test indirect jump done");
  endtask

  task automatic t_flag();
    for (int i = 0; i < 4; i++) begin
      core_in <= {i[1], i[0], 8'h00, 16'h0000};
      run({24'h0, 8'h7F, OPC_JC}, 2, 24'hFFFFF0, 1'b0, tgt(24'hFFFFF0, 2, 8'h7F, i[1]), 1'b0, 1'b0);
      run({16'h0, 8'h90, OPC_JE, OPC_ESCAPE}, 3, P, 1'b0, tgt(P, 3, 8'h90, i[0]), 1'b0, 1'b0);
      run({16'h0, 8'h90, OPC_JG, OPC_ESCAPE}, 3, P, 1'b0, tgt(P, 3, 8'h90, i == 0), 1'b0, 1'b0);
      run({16'h0, 8'h90, OPC_JLE, OPC_ESCAPE}, 3, P, 1'b0, tgt(P, 3, 8'h90, i != 0), 1'b0, 1'b0);
    end
    bus_read(REG_STATUS, 16'h0001, 16'h0001);
    bus_write(REG_CTRL, 16'h0001);
    run({24'h0, 8'h10, OPC_JE}, 2, P, 1'b0, tgt(P, 2, 8'h10, 1'b1), 1'b0, 1'b0);
    run({24'h0, 8'h10, OPC_JC}, 2, P, 1'b0, tgt(P, 2, 8'h10, 1'b1), 1'b0, 1'b0);
    $display("test flag jumps done");
  endtask

  task automatic t_ext();
    run({24'h0, OPC_JE, OPC_ESCAPE}, 2, P, 1'b0, 24'h0, 1'b1, 1'b0);
    run({8'h0, 8'hFE, 8'hE0, 8'h15, OPC_BIT_EXT}, 4, P, 1'b1, tgt(P, 4, 8'hFE, 1'b1), 1'b0, 1'b1);
    chk("bit_req", {1'b0, 1'b1, 8'hE0, 3'h5}, bit_req_q);
    bus_write(REG_CTRL, 16'h0000);
    run({8'h02, 8'hE0, 8'h36, OPC_BIT_EXT, OPC_ESCAPE}, 5, P, 1'b0, tgt(P, 5, 8'h02, 1'b1), 1'b0, 1'b0);
    chk("bit_req", {1'b0, 1'b0, 8'hE0, 3'h6}, bit_req_q);
    bus_read(REG_TARGET, 16'hFFFF, 16'h00F7);
    bus_read(REG_CTRL, 16'h0001, 16'h0000);
    $display("test extended bit branches done");
  endtask

  task automatic t_refuse();
    run({32'h0, OPC_JE}, 1, P, 1'b0, 24'h0, 1'b1, 1'b0);
    run({24'h0, OPC_JC, OPC_ESCAPE}, 2, P, 1'b0, 24'h0, 1'b1, 1'b0);
    run({16'h0, 8'h4A, OPC_BIT_EXT, OPC_ESCAPE}, 3, P, 1'b0, 24'h0, 1'b1, 1'b0);
    run({16'h0, 8'h28, OPC_BIT_EXT, OPC_ESCAPE}, 3, P, 1'b0, 24'h0, 1'b1, 1'b0);
    bus_read(REG_STATUS, 16'h0002, 16'h0002);
    bus_write(REG_STATUS, 16'h0002);
    bus_read(REG_STATUS, 16'h0002, 16'h0000);
    bus_read(4'hF, 16'hFFFF, 16'h0000);
    $display("test refusals done");
  endtask

  task automatic print_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    t_inc();
    t_legacy();
    t_ind();
    t_flag();
    t_ext();
    t_refuse();
    print_verdict();
  end

  initial begin
    #100000;
    n_mismatch++;
    print_verdict();
  end
endmodule
